// ---- src/rlsr_setup_bank.sv ----
// radio link setup register bank with address width, retry, channel and rate fields
`timescale 1ns/1ps
`include "rlsr_regs.svh"
module rlsr_setup_bank #(
	parameter int STEP_CYCLES = `RLSR_DELAY_STEP_CYCLES // cycles per 250 us delay step
) (
	input wire logic clock_in, // system clock, 125 MHz
	input wire logic rst_n_in, // async reset, active low
	input wire rlsr_pkg::rlsr_req_s req_in, // register command from the serial decoder
	output logic reg_hit_out, // request addresses this bank
	output logic [7:0] reg_rdata_out, // read data, valid the cycle after rd
	input wire logic [39:0] stored_addr_in, // a pipe address as stored
	output logic [39:0] active_addr_out, // the same address cut to the set width
	output logic [2:0] addr_bytes_out, // address width in bytes, 0 when illegal
	output logic addr_illegal_out, // width code 00 is set
	input wire logic tx_new_in, // pulse: a new packet starts
	input wire logic ack_fail_in, // pulse: transmission ended without acknowledge
	output logic resend_out, // pulse: start the retransmission now
	output logic give_up_out, // pulse: retry budget spent or disabled
	output logic [3:0] resend_count_out, // retransmissions of this packet
	output logic [6:0] channel_out, // radio channel select
	output rlsr_pkg::rlsr_rate_e rate_out, // decoded air data rate
	input wire logic synth_lock_in, // lock from the synthesizer
	output logic synth_lock_out // lock as seen by the radio state machine
);
	logic [1:0] addr_width_code_ff;
	logic [3:0] retry_delay_code_ff;
	logic [3:0] retry_limit_ff;
	logic [6:0] channel_select_ff;
	logic low_rate_select_ff;
	logic fast_rate_select_ff;
	logic force_lock_ff;
	rlsr_pkg::rlsr_retry_e retry_state_ff;
	logic [3:0] resend_cnt_ff;
	logic delay_start;
	logic delay_done;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] width_bytes(input logic [1:0] code);
		unique case (code)
			2'b01: width_bytes = 3'h3;
			2'b10: width_bytes = 3'h4;
			2'b11: width_bytes = 3'h5;
			2'b00: width_bytes = 3'h0;
		endcase
	endfunction

	function automatic logic hits(input logic [4:0] addr, input logic [4:0] ofs);
		hits = addr == ofs;
	endfunction

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_width_code_ff <= `RLSR_AW_RESET;
		end else if (req_in.wr && hits(req_in.addr, `RLSR_OFS_ADDR_WIDTH)) begin
			addr_width_code_ff <= req_in.wdata[`RLSR_AW_MSB:`RLSR_AW_LSB];
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			retry_delay_code_ff <= `RLSR_DELAY_RESET;
			retry_limit_ff <= `RLSR_LIMIT_RESET;
		end else if (req_in.wr && hits(req_in.addr, `RLSR_OFS_RESEND)) begin
			retry_delay_code_ff <= req_in.wdata[`RLSR_DELAY_MSB:`RLSR_DELAY_LSB];
			retry_limit_ff <= req_in.wdata[`RLSR_LIMIT_MSB:`RLSR_LIMIT_LSB];
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			channel_select_ff <= `RLSR_CHAN_RESET;
		end else if (req_in.wr && hits(req_in.addr, `RLSR_OFS_CHANNEL)) begin
			channel_select_ff <= req_in.wdata[`RLSR_CHAN_MSB:`RLSR_CHAN_LSB];
		end
	end

	// power and continuous-wave bits are not kept here and read as zero
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_rate_select_ff <= `RLSR_LOW_RATE_RESET;
			force_lock_ff <= `RLSR_LOCK_RESET;
			fast_rate_select_ff <= `RLSR_FAST_RATE_RESET;
		end else if (req_in.wr && hits(req_in.addr, `RLSR_OFS_RADIO)) begin
			low_rate_select_ff <= req_in.wdata[`RLSR_LOW_RATE_BIT];
			force_lock_ff <= req_in.wdata[`RLSR_LOCK_BIT];
			fast_rate_select_ff <= req_in.wdata[`RLSR_FAST_RATE_BIT];
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	assign reg_hit_out = hits(req_in.addr, `RLSR_OFS_ADDR_WIDTH)
		|| hits(req_in.addr, `RLSR_OFS_RESEND)
		|| hits(req_in.addr, `RLSR_OFS_CHANNEL)
		|| hits(req_in.addr, `RLSR_OFS_RADIO);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			reg_rdata_out <= 8'h00;
			unique case (1'b1)
				hits(req_in.addr, `RLSR_OFS_ADDR_WIDTH): begin
					reg_rdata_out[`RLSR_AW_MSB:`RLSR_AW_LSB] <= addr_width_code_ff;
				end
				hits(req_in.addr, `RLSR_OFS_RESEND): begin
					reg_rdata_out <= {retry_delay_code_ff, retry_limit_ff};
				end
				hits(req_in.addr, `RLSR_OFS_CHANNEL): begin
					reg_rdata_out[`RLSR_CHAN_MSB:`RLSR_CHAN_LSB] <= channel_select_ff;
				end
				hits(req_in.addr, `RLSR_OFS_RADIO): begin
					reg_rdata_out[`RLSR_LOW_RATE_BIT] <= low_rate_select_ff;
					reg_rdata_out[`RLSR_LOCK_BIT] <= force_lock_ff;
					reg_rdata_out[`RLSR_FAST_RATE_BIT] <= fast_rate_select_ff;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// field consumers
	// ------------------------------------------------------------
	assign addr_bytes_out = width_bytes(addr_width_code_ff);
	assign addr_illegal_out = addr_width_code_ff == 2'b00;

	// one width for all pipes; an illegal code passes nothing rather than guess a width
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_byte
			assign active_addr_out[gi*8 +: 8] = (3'(gi) < addr_bytes_out)
				? stored_addr_in[gi*8 +: 8] : 8'h00;
		end
	endgenerate

	assign channel_out = channel_select_ff;
	assign rate_out = low_rate_select_ff ? rlsr_pkg::RLSR_RATE_250K
		: (fast_rate_select_ff ? rlsr_pkg::RLSR_RATE_2M : rlsr_pkg::RLSR_RATE_1M);
	assign synth_lock_out = synth_lock_in || force_lock_ff;

	// ------------------------------------------------------------
	// retransmission control
	// ------------------------------------------------------------
	// a new packet in the same cycle clears the count and must not also start the timer
	assign delay_start = (retry_state_ff == rlsr_pkg::RLSR_RETRY_IDLE) && ack_fail_in
		&& !tx_new_in && (resend_cnt_ff < retry_limit_ff);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			retry_state_ff <= rlsr_pkg::RLSR_RETRY_IDLE;
			resend_cnt_ff <= 4'h0;
			resend_out <= 1'b0;
			give_up_out <= 1'b0;
		end else begin
			resend_out <= 1'b0;
			give_up_out <= 1'b0;
			unique case (retry_state_ff)
				rlsr_pkg::RLSR_RETRY_IDLE: begin
					if (tx_new_in) begin
						resend_cnt_ff <= 4'h0;
					end else if (delay_start) begin
						retry_state_ff <= rlsr_pkg::RLSR_RETRY_WAIT;
					end else if (ack_fail_in) begin
						give_up_out <= 1'b1;
					end
				end
				rlsr_pkg::RLSR_RETRY_WAIT: begin
					if (delay_done) begin
						resend_out <= 1'b1;
						resend_cnt_ff <= resend_cnt_ff + 4'h1;
						retry_state_ff <= rlsr_pkg::RLSR_RETRY_IDLE;
					end
				end
			endcase
		end
	end

	assign resend_count_out = resend_cnt_ff;

	rlsr_delay_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_delay (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(delay_start),
		.code_in(retry_delay_code_ff),
		.done_out(delay_done)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_width_decode: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		addr_bytes_out == ((addr_width_code_ff == 2'b00) ? 3'h0 : 3'(addr_width_code_ff) + 3'h2))
		else $error("address width decode wrong");

	a_upper_bytes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		addr_width_code_ff == 2'b01 |-> active_addr_out == {16'h0000, stored_addr_in[23:0]})
		else $error("upper address bytes not cut");

	a_rate_pair: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		low_rate_select_ff |-> rate_out == rlsr_pkg::RLSR_RATE_250K)
		else $error("fast rate bit not ignored");

	a_lock_force: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		force_lock_ff |-> synth_lock_out)
		else $error("forced lock not seen");

	a_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		req_in.rd && hits(req_in.addr, `RLSR_OFS_CHANNEL) |=> reg_rdata_out[7] == 1'b0)
		else $error("reserved bit reads one");

	a_write_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		req_in.wr && hits(req_in.addr, `RLSR_OFS_RESEND) ##1 !req_in.wr ##1 req_in.rd
		&& hits(req_in.addr, `RLSR_OFS_RESEND) && !req_in.wr
		|=> reg_rdata_out == $past(req_in.wdata, 3))
		else $error("read back differs from write");

	a_limit_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		retry_limit_ff == 4'h0 && ack_fail_in && !tx_new_in
		&& retry_state_ff == rlsr_pkg::RLSR_RETRY_IDLE |=> give_up_out && !resend_out)
		else $error("retransmit not disabled");

	a_retry_cap: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		resend_out |-> resend_cnt_ff <= retry_limit_ff && resend_cnt_ff != 4'h0)
		else $error("too many retransmits");

	a_channel_reset: assert property (@(posedge clock_in)
		$rose(rst_n_in) |-> channel_out == 7'h02)
		else $error("channel reset value wrong");

endmodule

// ---- src/rlsr_regs.svh ----
// register offsets, field positions, reset values and timing counts of the radio setup bank
`ifndef RLSR_REGS_SVH
`define RLSR_REGS_SVH

`define RLSR_OFS_ADDR_WIDTH 5'h03
`define RLSR_OFS_RESEND 5'h04
`define RLSR_OFS_CHANNEL 5'h05
`define RLSR_OFS_RADIO 5'h06

`define RLSR_AW_MSB 1
`define RLSR_AW_LSB 0
`define RLSR_DELAY_MSB 7
`define RLSR_DELAY_LSB 4
`define RLSR_LIMIT_MSB 3
`define RLSR_LIMIT_LSB 0
`define RLSR_CHAN_MSB 6
`define RLSR_CHAN_LSB 0
`define RLSR_LOW_RATE_BIT 5
`define RLSR_LOCK_BIT 4
`define RLSR_FAST_RATE_BIT 3

`define RLSR_AW_RESET 2'h3
`define RLSR_DELAY_RESET 4'h0
`define RLSR_LIMIT_RESET 4'h3
`define RLSR_CHAN_RESET 7'h02
`define RLSR_LOW_RATE_RESET 1'h0
`define RLSR_LOCK_RESET 1'h0
`define RLSR_FAST_RATE_RESET 1'h1

`define RLSR_CLOCK_MHZ 125
`define RLSR_DELAY_STEP_US 250
`define RLSR_DELAY_STEP_CYCLES (`RLSR_DELAY_STEP_US * `RLSR_CLOCK_MHZ)

`endif

// ---- src/rlsr_pkg.sv ----
// types shared by the radio setup bank
package rlsr_pkg;

	typedef enum logic [1:0] {
		RLSR_RATE_1M = 2'b00,
		RLSR_RATE_2M = 2'b01,
		RLSR_RATE_250K = 2'b10,
		RLSR_RATE_RSVD = 2'b11
	} rlsr_rate_e;

	typedef enum logic [0:0] {
		RLSR_RETRY_IDLE = 1'b0,
		RLSR_RETRY_WAIT = 1'b1
	} rlsr_retry_e;

	// one register command as delivered by the serial command decoder
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} rlsr_req_s;

endpackage

// ---- src/rlsr_delay_timer.sv ----
// retransmit delay timer: waits (code + 1) steps of a fixed cycle count
`timescale 1ns/1ps
`include "rlsr_regs.svh"
module rlsr_delay_timer #(
	parameter int STEP_CYCLES = `RLSR_DELAY_STEP_CYCLES
) (
	input wire logic clock_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic start_in, // pulse: a transmission has just ended
	input wire logic [3:0] code_in, // delay code sampled at start
	output logic done_out // pulse: the wait is over
);
	logic [15:0] pre_ff;
	logic [3:0] steps_ff;
	logic busy_ff;
	logic tick;

	// ------------------------------------------------------------
	// step divider
	// ------------------------------------------------------------
	// restarts with every start so each step is a full step long
	assign tick = busy_ff && (pre_ff == 16'(STEP_CYCLES - 1));

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_ff <= 16'h0000;
		end else if (start_in || tick) begin
			pre_ff <= 16'h0000;
		end else if (busy_ff) begin
			pre_ff <= pre_ff + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// step counter
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			steps_ff <= 4'h0;
			busy_ff <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				steps_ff <= code_in;
				busy_ff <= 1'b1;
			end else if (tick) begin
				if (steps_ff == 4'h0) begin
					busy_ff <= 1'b0;
					done_out <= 1'b1;
				end else begin
					steps_ff <= steps_ff - 4'h1;
				end
			end
		end
	end

	// helper: cycles since the last start, and the code it carried
	logic [19:0] since_ff;
	logic [3:0] code_ff;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			since_ff <= 20'h0_0000;
			code_ff <= 4'h0;
		end else if (start_in) begin
			since_ff <= 20'h0_0001;
			code_ff <= code_in;
		end else if (since_ff != 20'hF_FFFF) begin
			since_ff <= since_ff + 20'h0_0001;
		end
	end

	a_delay_length: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		done_out |-> since_ff == 20'((32'(code_ff) + 1) * STEP_CYCLES + 1))
		else $error("retransmit delay length wrong");

endmodule

// ---- bench/rlsr_host_model.sv ----
// host side model issuing register commands to the radio setup bank
`timescale 1ns/1ps
module rlsr_host_model (
	input wire logic clock_in, // system clock
	input wire logic [7:0] rdata_in, // read data from the bank
	output rlsr_pkg::rlsr_req_s req_out // register command to the bank
);
	initial begin
		req_out = '0;
	end

	// --------------------------------------------------------------
	// command cycles
	// --------------------------------------------------------------
	// released fields show the inverse of the last value so stale data never matches
	task automatic write(input logic [4:0] addr, input logic [7:0] data);
		@(posedge clock_in);
		#1;
		req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clock_in);
		#1;
		req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
	endtask

	task automatic read(input logic [4:0] addr, output logic [7:0] data);
		@(posedge clock_in);
		#1;
		req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~req_out.wdata};
		@(posedge clock_in);
		#1;
		req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~req_out.wdata};
		data = rdata_in;
	endtask
endmodule

// ---- bench/test_radio_link_setup_registers.sv ----
// self-checking bench for the radio setup register bank
`timescale 1ns/1ps
`include "rlsr_regs.svh"
module test_radio_link_setup_registers;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] w;
		logic [7:0] r;
	} rlsr_row_s;

	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	rlsr_pkg::rlsr_req_s req;
	logic reg_hit, resend, give_up, synth_lock_out, addr_illegal;
	logic hit_at_rd;
	logic [7:0] rdata, rd;
	logic [39:0] stored_addr = 40'h11_2233_4455;
	logic [39:0] active_addr;
	logic [2:0] addr_bytes;
	logic tx_new = 1'b0;
	logic ack_fail = 1'b0;
	logic synth_lock_in = 1'b0;
	logic [3:0] resend_count;
	logic [6:0] channel;
	rlsr_pkg::rlsr_rate_e rate;
	int err_count = 0;
	int n_tests = 0;
	int n;
	rlsr_row_s rows [10] = '{
		'{5'h03, 8'hff, 8'h03}, '{5'h03, 8'h01, 8'h01}, '{5'h04, 8'h25, 8'h25},
		'{5'h04, 8'hf0, 8'hf0}, '{5'h05, 8'hff, 8'h7f}, '{5'h05, 8'h00, 8'h00},
		'{5'h06, 8'hff, 8'h38}, '{5'h06, 8'h20, 8'h20}, '{5'h07, 8'hff, 8'h00},
		'{5'h00, 8'haa, 8'h00}};

	always #4 clock_in = ~clock_in;

	rlsr_host_model i_host (.clock_in(clock_in), .rdata_in(rdata), .req_out(req));

	rlsr_setup_bank #(.STEP_CYCLES(4)) i_dut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req), .reg_hit_out(reg_hit),
		.reg_rdata_out(rdata), .stored_addr_in(stored_addr), .active_addr_out(active_addr),
		.addr_bytes_out(addr_bytes), .addr_illegal_out(addr_illegal), .tx_new_in(tx_new),
		.ack_fail_in(ack_fail), .resend_out(resend), .give_up_out(give_up),
		.resend_count_out(resend_count), .channel_out(channel), .rate_out(rate),
		.synth_lock_in(synth_lock_in), .synth_lock_out(synth_lock_out));

	// the hit flag follows the address, so it is caught while the read stands
	always @(posedge clock_in) begin
		if (req.rd) begin
			hit_at_rd <= reg_hit;
		end
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic do_reset();
		rst_n_in = 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
	endtask

	// pulse ack_fail and count edges until resend or give up; extra repeats ack in mid-wait
	task automatic ack_round(input bit extra);
		@(posedge clock_in);
		#1;
		ack_fail = 1'b1;
		@(posedge clock_in);
		#1;
		n = 0;
		while (!(resend === 1'b1 || give_up === 1'b1)) begin
			ack_fail = extra && n == 3;
			@(posedge clock_in);
			#1;
			n++;
			if (n > 200) begin
				err_count++;
				conclude();
			end
		end
		ack_fail = 1'b0;
	endtask

	task automatic new_packet();
		@(posedge clock_in);
		#1;
		tx_new = 1'b1;
		@(posedge clock_in);
		#1;
		tx_new = 1'b0;
	endtask

	initial begin
		do_reset();
		// --------------------------------------------------------------
		// ordinary read back rows
		// --------------------------------------------------------------
		foreach (rows[i]) begin
			i_host.write(rows[i].a, rows[i].w);
			i_host.read(rows[i].a, rd);
			check(rd, rows[i].r);
			check(hit_at_rd, rows[i].a inside {[5'h03:5'h06]});
			if (rows[i].a == `RLSR_OFS_CHANNEL) check(channel, rows[i].r[6:0]);
		end
		// --------------------------------------------------------------
		// reset values, also after a second reset in mid-run
		// --------------------------------------------------------------
		do_reset();
		i_host.read(`RLSR_OFS_ADDR_WIDTH, rd);
		check(rd, 8'h03);
		i_host.read(`RLSR_OFS_RESEND, rd);
		check(rd, 8'h03);
		i_host.read(`RLSR_OFS_CHANNEL, rd);
		check(rd, 8'h02);
		i_host.read(`RLSR_OFS_RADIO, rd);
		check(rd, 8'h08);
		check(channel, 7'h02);
		check(addr_bytes, 3'h5);
		// --------------------------------------------------------------
		// address width codes and cut address
		// --------------------------------------------------------------
		for (int c = 0; c < 4; c++) begin
			i_host.write(`RLSR_OFS_ADDR_WIDTH, 8'(c));
			#1;
			check(addr_bytes, c == 0 ? 3'h0 : 3'(c + 2));
			check(addr_illegal, c == 0);
			check(active_addr, c == 0 ? 40'h0 : stored_addr & ({40{1'b1}} >> (8 * (3 - c))));
		end
		// --------------------------------------------------------------
		// data rate pairs and forced lock
		// --------------------------------------------------------------
		for (int v = 0; v < 4; v++) begin
			i_host.write(`RLSR_OFS_RADIO, {2'b00, v[1], 1'b0, v[0], 3'b000});
			#1;
			check(rate, v[1] ? 2'b10 : {1'b0, v[0]});
		end
		i_host.write(`RLSR_OFS_RADIO, 8'h10);
		#1;
		check(synth_lock_out, 1'b1);
		i_host.write(`RLSR_OFS_RADIO, 8'h00);
		#1;
		check(synth_lock_out, 1'b0);
		synth_lock_in = 1'b1;
		#1;
		check(synth_lock_out, 1'b1);
		// --------------------------------------------------------------
		// retransmission: delay code 1, limit 2, ack in mid-wait ignored
		// --------------------------------------------------------------
		// the pulse shows (code + 1) steps of 4 cycles plus one cycle after the fail edge
		i_host.write(`RLSR_OFS_RESEND, 8'h12);
		new_packet();
		check(resend_count, 4'h0);
		ack_round(1'b0);
		check({resend, give_up, 4'(n)}, {2'b10, 4'h9});
		check(resend_count, 4'h1);
		ack_round(1'b1);
		check({resend, give_up, 4'(n)}, {2'b10, 4'h9});
		check(resend_count, 4'h2);
		ack_round(1'b0);
		check({resend, give_up, 4'(n)}, {2'b01, 4'h0});
		// highest delay code with limit 1
		i_host.write(`RLSR_OFS_RESEND, 8'hf1);
		new_packet();
		ack_round(1'b0);
		check({resend, give_up, 8'(n)}, {2'b10, 8'h41});
		// limit zero disables retransmission
		i_host.write(`RLSR_OFS_RESEND, 8'h50);
		new_packet();
		ack_round(1'b0);
		check({resend, give_up, 4'(n)}, {2'b01, 4'h0});
		check(resend_count, 4'h0);
		conclude();
	end
endmodule
